// ### include/smb_defs.svh
// Purpose: shared offsets, field positions, reset values and timing counts
// Assumes: included by bare name from both ends, the link checker and the bench
// Notes: register numbers are the device pointer values
`ifndef SMB_DEFS_SVH
`define SMB_DEFS_SVH
`define CLK_HZ 20000000
`define SMB_TIMEOUT_MS 25
`define SMB_TIMEOUT_CYC (`SMB_TIMEOUT_MS * (`CLK_HZ / 1000))
`define SCL_QUARTER_CYC 2
`define DEV_ADDR_MAIN 7'h4C
`define DEV_ADDR_ALT 7'h4D
`define ALERT_RESP_ADDR 7'h0C
`define REG_STATUS 8'h02
`define REG_CFG_RD 8'h03
`define REG_CFG_WR 8'h09
`define REG_ONESHOT 8'h0F
`define REG_CONSEC 8'h22
`define CFG_STANDBY_BIT 6
`define STATUS_OPEN_BIT 2
`define CONSEC_TIMEOUT_BIT 7
`define CFG_RESET 8'h00
`define CONSEC_RESET 8'h01
`define PTR_RESET 8'h00
`define HOST_CMD_OFS 32'h0000_0000
`define HOST_WDATA_OFS 32'h0000_0004
`define HOST_STAT_OFS 32'h0000_0008
`define CMD_READ_BIT 7
`define CMD_GO_BIT 16
`endif

// ### include/smb_if.sv
// Purpose: open-drain two-wire link plus shared alert line
// Assumes: pull-ups on every wire; enable low means the end pulls low
// Notes: bench may wire-AND further devices onto scl, sda and alert_n
`timescale 1ns/100ps
interface smb_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic dev_alert_o;
  logic dev_alert_oe_n;
  logic scl;
  logic sda;
  logic alert_n;
  // wired-AND with pull-up resolution
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  assign alert_n = dev_alert_oe_n | dev_alert_o;
  modport host (output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n,
    input sda, alert_n);
  modport dev (output dev_sda_o, dev_sda_oe_n, dev_alert_o, dev_alert_oe_n,
    input scl, sda);
endinterface

// ### include/smb_pkg.sv
// Purpose: state types for both ends of the two-wire link
// Assumes: nothing
// Notes: constants live in smb_defs.svh
package smb_pkg;
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACK, D_RX, D_TX, D_IGNORE} dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;
endpackage

// ### logic/smb_host_ctrl.sv
// Purpose: two-wire bus master driven from AHB-Lite registers
// Assumes: single slave on AHB; no clock stretching on the link
// Notes: one transaction per command; zero-wait AHB answers
`timescale 1ns/100ps
`include "smb_defs.svh"
module smb_host_ctrl
  import smb_pkg::*;
#(
  parameter int QUARTER_CYC = `SCL_QUARTER_CYC
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // link
  smb_if.host link
);
  // the quarter divider is an eight-bit counter
  if (QUARTER_CYC < 1 || QUARTER_CYC > 255)
  begin : g_bad_quarter
    $error("QUARTER_CYC out of range");
  end

  logic [1:0] sda_sy;
  logic [1:0] alert_sy;
  host_state_t st, next_st;
  logic [7:0] div, next_div;
  logic [1:0] q, next_q;
  logic [1:0] bi, next_bi;
  logic [3:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  logic [6:0] addr, next_addr;
  logic rd, next_rd;
  logic [1:0] nwr, next_nwr;
  logic [15:0] wdata, next_wdata;
  logic nack, next_nack;
  logic [7:0] rdata, next_rdata;
  logic sda_rel, next_sda_rel;
  logic scl_rel, next_scl_rel;
  logic a_wr, next_a_wr;
  logic [31:0] a_addr, next_a_addr;
  logic [31:0] next_hrdata;
  logic tick, txb, busy, last;

  // line inputs pass two flops before use
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sda_sy <= 2'h3;
      alert_sy <= 2'h3;
    end
    else
    begin
      sda_sy <= {sda_sy[0], link.sda};
      alert_sy <= {alert_sy[0], link.alert_n};
    end
  end

  assign busy = st != H_IDLE;
  assign tick = busy && div == 8'(QUARTER_CYC - 1);
  assign txb = bi == 2'h0 || !rd; // read data byte and its nack: master releases
  assign last = rd ? bi == 2'h1 : bi == nwr;

  // register access and bit engine
  always_comb
  begin
    next_st = st;
    next_div = tick ? 8'h00 : (busy ? div + 8'h01 : 8'h00);
    next_q = q;
    next_bi = bi;
    next_bitn = bitn;
    next_sh = sh;
    next_addr = addr;
    next_rd = rd;
    next_nwr = nwr;
    next_wdata = wdata;
    next_nack = nack;
    next_rdata = rdata;
    next_sda_rel = sda_rel;
    next_scl_rel = scl_rel;
    next_a_wr = 1'b0;
    next_a_addr = a_addr;
    next_hrdata = hrdata;
    // address phase: latch and prepare read data; only whole words are served
    if (hsel && htrans[1] && hready && hsize == 3'h2)
    begin
      next_a_wr = hwrite;
      next_a_addr = haddr;
      if (haddr[3:0] == `HOST_CMD_OFS)
        next_hrdata = {15'h0000, busy, 6'h00, nwr, rd, addr};
      else if (haddr[3:0] == `HOST_WDATA_OFS)
        next_hrdata = {16'h0000, wdata};
      else if (haddr[3:0] == `HOST_STAT_OFS)
        next_hrdata = {16'h0000, rdata, 5'h00, ~alert_sy[1], nack, busy};
      else
        next_hrdata = 32'h0000_0000;
    end
    // data phase write; a command while busy is dropped
    if (a_wr && a_addr[3:0] == `HOST_WDATA_OFS)
      next_wdata = hwdata[15:0];
    if (a_wr && a_addr[3:0] == `HOST_CMD_OFS && hwdata[`CMD_GO_BIT] && !busy)
    begin
      next_addr = hwdata[6:0];
      next_rd = hwdata[`CMD_READ_BIT];
      next_nwr = hwdata[9:8];
      next_nack = 1'b0;
      next_st = H_START;
      next_q = 2'h0;
    end
    if (tick)
    begin
      next_q = q + 2'h1;
      unique case (st)
        H_START:
          unique case (q)
            2'h0:
            begin
              next_scl_rel = 1'b1;
              next_sda_rel = 1'b1;
            end
            2'h1: next_sda_rel = 1'b0;
            2'h2: next_scl_rel = 1'b0;
            2'h3:
            begin
              next_st = H_BIT;
              next_bi = 2'h0;
              next_bitn = 4'h0;
              next_sh = {addr, rd};
            end
          endcase
        H_BIT:
          unique case (q)
            2'h0: next_sda_rel = (txb && bitn != 4'h8) ? sh[7] : 1'b1;
            2'h1: next_scl_rel = 1'b1;
            2'h2:
              if (bitn != 4'h8 && !txb)
                next_rdata = {rdata[6:0], sda_sy[1]};
              else if (bitn == 4'h8 && txb)
                next_nack = sda_sy[1];
            2'h3:
            begin
              next_scl_rel = 1'b0;
              if (bitn != 4'h8)
              begin
                next_sh = {sh[6:0], 1'b1};
                next_bitn = bitn + 4'h1;
              end
              else if (nack || last)
                next_st = H_STOP;
              else
              begin
                next_bi = bi + 2'h1;
                next_bitn = 4'h0;
                next_sh = bi == 2'h0 ? wdata[7:0] : wdata[15:8];
              end
            end
          endcase
        H_STOP:
          unique case (q)
            2'h0: next_sda_rel = 1'b0;
            2'h1: next_scl_rel = 1'b1;
            2'h2: next_sda_rel = 1'b1;
            2'h3: next_st = H_IDLE;
          endcase
        default:
          next_st = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= H_IDLE;
      div <= '0;
      q <= '0;
      bi <= '0;
      bitn <= '0;
      sh <= '0;
      addr <= '0;
      rd <= 1'b0;
      nwr <= '0;
      wdata <= '0;
      nack <= 1'b0;
      rdata <= '0;
      sda_rel <= 1'b1;
      scl_rel <= 1'b1;
      a_wr <= 1'b0;
      a_addr <= '0;
      hrdata <= '0;
    end
    else
    begin
      st <= next_st;
      div <= next_div;
      q <= next_q;
      bi <= next_bi;
      bitn <= next_bitn;
      sh <= next_sh;
      addr <= next_addr;
      rd <= next_rd;
      nwr <= next_nwr;
      wdata <= next_wdata;
      nack <= next_nack;
      rdata <= next_rdata;
      sda_rel <= next_sda_rel;
      scl_rel <= next_scl_rel;
      a_wr <= next_a_wr;
      a_addr <= next_a_addr;
      hrdata <= next_hrdata;
    end
  end

  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0;
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe_n = scl_rel;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = sda_rel;
endmodule // smb_host_ctrl

// ### logic/smb_temp_slave.sv
// Purpose: two-wire slave end of a temperature monitor with alert and standby
// Assumes: hclk far faster than scl; scl and sda synchronised before use
// Notes: registers other than pointer, config, status, consec and one-shot are user-side
//
// Function
// - answer own address 0x4C, variant 0x4D
// - start condition then eight address bits
// - matching address acknowledged by pulling data low
// - direction bit 0 write, 1 read
// - byte is eight bits plus acknowledge
// - data rising while clock high means stop
// - master ends write with stop
// - master ends read with nack then stop
// - direction fixed for whole transaction
// - writes one or two bytes, reads one
// - first write byte loads pointer, second stores
// - read returns register at current pointer
// - separate read and write register addresses
// - alert pulled low on limit or open sensor
// - alert response read returns own address
// - lowest address wins alert response by arbitration
// - alert released after response if cause cleared
// - master repeats alert response while line low
// - config bit 6 selects standby, halts converter
// - write to 0x0F in standby triggers conversion
// - limit writes in standby may still alert
// - open sensor sampled at conversion start sets bit2
// - optional bus timeout after 25 ms idle
// - failsafe mode latches only open flag
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
`include "smb_defs.svh"
module smb_temp_slave
  import smb_pkg::*;
#(
  parameter bit ADDR_VARIANT = 1'b0,
  parameter int TIMEOUT_CYC = `SMB_TIMEOUT_CYC
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link
  smb_if.dev link,
  // converter side
  input wire logic alert_mode,
  input wire logic out_of_limit,
  input wire logic conv_start,
  input wire logic open_comparator,
  input wire logic [7:0] status_live,
  output logic standby,
  output logic one_shot,
  // user register file
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [6:0] OWN_ADDR = ADDR_VARIANT ? `DEV_ADDR_ALT : `DEV_ADDR_MAIN;

  // the idle counter needs at least two states to mark a timeout
  if (TIMEOUT_CYC < 2)
  begin : g_bad_timeout
    $error("TIMEOUT_CYC too small");
  end

  logic [2:0] scl_sy;
  logic [2:0] sda_sy;
  dev_state_t st, next_st;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic [1:0] bidx, next_bidx;
  logic rd, next_rd;
  logic ara, next_ara;
  logic drv, next_drv;
  logic [7:0] ptr, next_ptr;
  logic [7:0] cfg, next_cfg;
  logic [7:0] consec, next_consec;
  logic open_flag, next_open_flag;
  logic alert_lat, next_alert_lat;
  logic [TW-1:0] to_cnt, next_to_cnt;
  logic next_one_shot, next_reg_wr;
  logic [7:0] next_reg_wdata;
  logic scl_rise, scl_fall, start_c, stop_c, timeout, cause;
  logic [7:0] rd_byte;

  // two-flop synchronisers; bit 2 is a delayed copy for edge finding
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
    end
    else
    begin
      scl_sy <= {scl_sy[1:0], link.scl};
      sda_sy <= {sda_sy[1:0], link.sda};
    end
  end

  assign scl_rise = scl_sy[1] & ~scl_sy[2];
  assign scl_fall = ~scl_sy[1] & scl_sy[2];
  assign start_c = scl_sy[1] & scl_sy[2] & sda_sy[2] & ~sda_sy[1];
  assign stop_c = scl_sy[1] & scl_sy[2] & ~sda_sy[2] & sda_sy[1];
  assign timeout = consec[`CONSEC_TIMEOUT_BIT] && to_cnt == TW'(TIMEOUT_CYC - 1);
  assign cause = out_of_limit | open_flag;

  // read mux; only the open flag is latched here, limit flags come live
  always_comb
  begin
    unique case (ptr)
      `REG_CFG_RD: rd_byte = cfg;
      `REG_STATUS: rd_byte = {status_live[7:3], open_flag, status_live[1:0]};
      `REG_CONSEC: rd_byte = consec;
      default: rd_byte = reg_rdata;
    endcase
  end

  // bus engine, register writes and alert state
  always_comb
  begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_bidx = bidx;
    next_rd = rd;
    next_ara = ara;
    next_drv = drv;
    next_ptr = ptr;
    next_cfg = cfg;
    next_consec = consec;
    next_open_flag = open_flag;
    next_alert_lat = alert_lat;
    next_one_shot = 1'b0;
    next_reg_wr = 1'b0;
    next_reg_wdata = reg_wdata;
    next_to_cnt = (st == D_IDLE || scl_rise || scl_fall) ? '0 : to_cnt + TW'(1);
    if (start_c)
    begin
      next_st = D_ADDR;
      next_cnt = '0;
      next_drv = 1'b0;
      next_ara = 1'b0;
      next_bidx = '0;
    end
    else if (stop_c || timeout)
    begin
      next_st = D_IDLE;
      next_drv = 1'b0;
    end
    else
    begin
      unique case (st)
        D_IDLE, D_IGNORE:
          next_drv = 1'b0;
        D_ADDR, D_RX:
          if (scl_rise)
          begin
            next_sh = {sh[6:0], sda_sy[1]};
            next_cnt = cnt + 4'h1;
          end
          else if (scl_fall && cnt == 4'h8)
          begin
            next_st = D_ACK;
            next_drv = 1'b1;
            if (st == D_ADDR)
            begin
              next_rd = sh[0];
              if (sh[7:1] == `ALERT_RESP_ADDR && sh[0] && alert_lat)
                next_ara = 1'b1;
              else if (sh[7:1] != OWN_ADDR)
              begin
                next_st = D_IGNORE;
                next_drv = 1'b0;
              end
            end
            else if (bidx == 2'h0)
            begin
              next_ptr = sh;
              next_bidx = 2'h1;
            end
            else if (bidx == 2'h1)
            begin
              next_bidx = 2'h2;
              unique case (ptr)
                `REG_CFG_WR: next_cfg = sh;
                `REG_CONSEC: next_consec = sh;
                `REG_ONESHOT: next_one_shot = cfg[`CFG_STANDBY_BIT];
                default:
                begin
                  next_reg_wr = 1'b1;
                  next_reg_wdata = sh;
                end
              endcase
            end
            else
            begin
              next_st = D_IGNORE;
              next_drv = 1'b0;
            end
          end
        D_ACK:
          if (scl_fall)
          begin
            next_cnt = '0;
            if (rd)
            begin
              next_st = D_TX;
              next_sh = ara ? {OWN_ADDR, 1'b1} : rd_byte;
              next_drv = ara ? ~OWN_ADDR[6] : ~rd_byte[7];
              if (!ara && ptr == `REG_STATUS)
                next_open_flag = 1'b0; // status read clears the latched flag
            end
            else
            begin
              next_st = D_RX;
              next_drv = 1'b0;
            end
          end
        D_TX:
          if (scl_rise)
          begin
            next_cnt = cnt + 4'h1;
            next_sh = {sh[6:0], 1'b1};
            if (!drv && !sda_sy[1])
            begin
              next_st = D_IGNORE;
              next_ara = 1'b0;
            end
          end
          else if (scl_fall)
          begin
            if (cnt == 4'h8)
            begin
              next_st = D_IGNORE;
              next_drv = 1'b0;
              if (ara && !cause)
                next_alert_lat = 1'b0;
            end
            else
              next_drv = ~sh[7];
          end
        default:
          next_st = D_IDLE;
      endcase
    end
    // hardware set beats the clear from a status read
    if (conv_start && open_comparator && !cfg[`CFG_STANDBY_BIT])
      next_open_flag = 1'b1;
    if (conv_start && open_comparator && one_shot)
      next_open_flag = 1'b1;
    // out-of-limit is evaluated even in standby, so limit writes can alert
    if (alert_mode && cause)
      next_alert_lat = 1'b1;
    if (!alert_mode)
      next_alert_lat = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= D_IDLE;
      cnt <= '0;
      sh <= '0;
      bidx <= '0;
      rd <= 1'b0;
      ara <= 1'b0;
      drv <= 1'b0;
      ptr <= `PTR_RESET;
      cfg <= `CFG_RESET;
      consec <= `CONSEC_RESET;
      open_flag <= 1'b0;
      alert_lat <= 1'b0;
      to_cnt <= '0;
      one_shot <= 1'b0;
      reg_wr <= 1'b0;
      reg_wdata <= '0;
    end
    else
    begin
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      bidx <= next_bidx;
      rd <= next_rd;
      ara <= next_ara;
      drv <= next_drv;
      ptr <= next_ptr;
      cfg <= next_cfg;
      consec <= next_consec;
      open_flag <= next_open_flag;
      alert_lat <= next_alert_lat;
      to_cnt <= next_to_cnt;
      one_shot <= next_one_shot;
      reg_wr <= next_reg_wr;
      reg_wdata <= next_reg_wdata;
    end
  end

  assign standby = cfg[`CFG_STANDBY_BIT];
  assign reg_addr = ptr;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = ~drv;
  assign link.dev_alert_o = 1'b0;
  assign link.dev_alert_oe_n = ~alert_lat;
endmodule // smb_temp_slave

// ### test/smb_link_chk.sv
// Purpose: wire-level checks on the two-wire link between host and slave
// Assumes: one slave on the link; a host bit keeps scl high for four hclk
// Notes: frames are decoded here from the resolved scl and sda levels
`timescale 1ns/100ps
`include "smb_defs.svh"
module smb_link_chk
  import smb_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = `DEV_ADDR_MAIN
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic alert_n,
  input wire logic dev_sda_oe_n
);
  logic scl_d, sda_d, rd, ara, hit, first_byte, rise, start;
  logic [3:0] bit_cnt;
  logic [7:0] shift, ara_byte;
  assign rise = scl & ~scl_d;
  assign start = scl & scl_d & sda_d & ~sda;
  assign ara_byte = {OWN_ADDR, 1'b1};
  // frame decoder; a rise with bit_cnt 9 may be a stop, so it is left unchecked
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      bit_cnt <= 4'h0;
      first_byte <= 1'b0;
      shift <= 8'h00;
      rd <= 1'b0;
      ara <= 1'b0;
      hit <= 1'b0;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
      if (start)
      begin
        bit_cnt <= 4'h0;
        first_byte <= 1'b1;
        ara <= 1'b0;
      end
      else if (rise)
      begin
        bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
        if (bit_cnt < 4'h8)
          shift <= {shift[6:0], sda};
        if (bit_cnt == 4'h9)
          first_byte <= 1'b0;
        if (first_byte && bit_cnt == 4'h8)
        begin
          rd <= shift[0];
          hit <= !dev_sda_oe_n;
          ara <= (shift == {`ALERT_RESP_ADDR, 1'b1}) && !alert_n;
        end
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // one data bit: scl high for two quarters, then low
  sequence scl_held;
    scl [*4] ##1 !scl;
  endsequence
  sequence sda_held;
    $stable(sda) [*3];
  endsequence
  addr_quiet_a: assert property (first_byte && rise && bit_cnt < 4'h8 |-> dev_sda_oe_n)
    else $error("slave drove data during the address byte");
  addr_ack_a: assert property (first_byte && rise && bit_cnt == 4'h8 |->
    dev_sda_oe_n == !(shift[7:1] == OWN_ADDR || (shift == {`ALERT_RESP_ADDR, 1'b1} && !alert_n)))
    else $error("address acknowledge wrong");
  dev_edge_a: assert property (scl && scl_d |-> $stable(dev_sda_oe_n))
    else $error("slave changed data while clock high");
  sda_steady_a: assert property (rise && bit_cnt < 4'h9 |=> sda_held)
    else $error("data moved while clock high");
  scl_high_a: assert property (rise && bit_cnt < 4'h9 |-> scl_held)
    else $error("clock high time wrong");
  rd_release_a: assert property (!first_byte && rd && rise && bit_cnt == 4'h8 |-> dev_sda_oe_n)
    else $error("slave drove the read acknowledge slot");
  wr_quiet_a: assert property (!first_byte && !rd && rise && bit_cnt < 4'h8 |-> dev_sda_oe_n)
    else $error("slave drove data in a write");
  wr_ack_a: assert property (hit && !first_byte && !rd && rise && bit_cnt == 4'h8 |->
    !dev_sda_oe_n)
    else $error("write byte not acknowledged");
  ara_reply_a: assert property (ara && !first_byte && rise && bit_cnt > 4'h0 && bit_cnt < 4'h8
    |-> sda == ara_byte[7 - bit_cnt])
    else $error("alert reply bit wrong");
  alert_hold_a: assert property ($rose(alert_n) |-> ara)
    else $error("alert released outside an alert reply");
endmodule // smb_link_chk

// ### test/smbus_slave_alert_standby_tb_top.sv
// Purpose: drives the host over AHB-Lite and checks the slave across the link
// Assumes: slave at the main address; the bench holds the user register file
// Notes: expectations come from the small model kept in m_ variables
`timescale 1ns/100ps
`include "smb_defs.svh"
module smbus_slave_alert_standby_tb_top
  import smb_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, standby, one_shot, reg_wr;
  logic alert_mode = 1'b1, out_of_limit = 1'b0, conv_start = 1'b0, open_comparator = 1'b0;
  logic [7:0] status_live = 8'h00, reg_addr, reg_wdata, reg_rdata, m_cfg = `CFG_RESET;
  logic [7:0] ufile [256];
  logic m_open = 1'b0;
  int m_user [256];
  int m_ptr = 0, n_errors = 0, total_checks = 0, shots = 0;
  integer seed = 32'hDADE;
  logic [7:0] adr_q [$];
  assign hready = hreadyout;
  assign reg_rdata = ufile[reg_addr];
  always #25 hclk = ~hclk;
  // user register file behind the slave, and one-shot pulse count
  always @(posedge hclk)
  begin
    if (one_shot === 1'b1)
      shots++;
    if (reg_wr === 1'b1)
      ufile[reg_addr] <= reg_wdata;
  end
  smb_if bus ();
  smb_temp_slave #(.TIMEOUT_CYC(200)) smb_temp_slave_inst (.hclk(hclk), .hresetn(hresetn),
    .link(bus.dev), .alert_mode(alert_mode), .out_of_limit(out_of_limit),
    .conv_start(conv_start), .open_comparator(open_comparator), .status_live(status_live),
    .standby(standby), .one_shot(one_shot), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  smb_host_ctrl smb_host_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(bus.host));
  smb_link_chk #(.OWN_ADDR(`DEV_ADDR_MAIN)) smb_link_chk_inst (.hclk(hclk), .hresetn(hresetn),
    .scl(bus.scl), .sda(bus.sda), .alert_n(bus.alert_n), .dev_sda_oe_n(bus.dev_sda_oe_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one single AHB transfer; address held until hready, data taken at the next
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic smb(input logic [6:0] a, input logic rd, input logic [1:0] n,
    input logic [15:0] wd, output logic [31:0] st);
    logic [31:0] r;
    int k;
    k = 0;
    ahb(1'b1, `HOST_WDATA_OFS, {16'h0, wd}, r);
    ahb(1'b1, `HOST_CMD_OFS, {15'h0, 1'b1, 6'h0, n, rd, a}, r);
    do
    begin
      ahb(1'b0, `HOST_STAT_OFS, 32'h0, st);
      k++;
    end while (st[0] !== 1'b0 && k < 3000);
    check({7'h0, st[0]}, 8'h00);
  endtask
  task automatic dev_wr(input logic [1:0] n, input logic [7:0] b1, input logic [7:0] b2);
    logic [31:0] st;
    smb(`DEV_ADDR_MAIN, 1'b0, n, {b2, b1}, st);
    check(st[7:0] & 8'h03, 8'h00);
    m_ptr = b1;
    if (n == 2'h2 && b1 == `REG_CFG_WR)
      m_cfg = b2;
    else if (n == 2'h2 && b1 != `REG_ONESHOT)
      m_user[b1] = b2;
    check(reg_addr, b1);
  endtask
  task automatic dev_rd(input logic [6:0] a, input logic [7:0] exp);
    logic [31:0] st;
    smb(a, 1'b1, 2'h0, 16'h0, st);
    check(st[7:0] & 8'h03, 8'h00);
    check(st[15:8], exp);
  endtask
  task automatic alert_is(input logic b);
    logic [31:0] r;
    int k;
    k = 0;
    do
    begin
      ahb(1'b0, `HOST_STAT_OFS, 32'h0, r);
      k++;
    end while (r[2] !== b && k < 40);
    check({7'h0, r[2]}, {7'h0, b});
  endtask
  function automatic logic [7:0] m_val(input int p);
    case (p)
      8'h02: return (status_live & 8'hFB) | {5'h0, m_open, 2'h0};
      8'h03: return m_cfg;
      8'h22: return `CONSEC_RESET;
      default: return m_user[p][7:0];
    endcase
  endfunction
  // hang guard: the whole sequence needs well under a quarter of this
  initial
  begin
    #3000000;
    n_errors++;
    wrap_up();
  end
  initial
  begin
    logic [31:0] st;
    logic [7:0] p;
    logic [6:0] al [4];
    for (int i = 0; i < 256; i++)
    begin
      ufile[i] = 8'($random(seed));
      m_user[i] = ufile[i];
    end
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({7'h0, standby}, 8'h00);
    check(reg_addr, `PTR_RESET);
    dev_rd(`DEV_ADDR_MAIN, m_val(0));
    dev_wr(2'h1, `REG_CONSEC, 8'h00);
    dev_rd(`DEV_ADDR_MAIN, m_val(m_ptr));
    $display("test reset_values done");
    al = '{7'h4D, `ALERT_RESP_ADDR, 7'h00, `DEV_ADDR_MAIN};
    al[2] = 7'($random(seed));
    foreach (al[i])
    begin
      smb(al[i], 1'b0, 2'h0, 16'h0, st);
      check({7'h0, st[1]}, {7'h0, al[i] != `DEV_ADDR_MAIN});
    end
    $display("test addressing done");
    dev_wr(2'h2, `REG_CFG_WR, 8'h40);
    check({7'h0, standby}, 8'h01);
    dev_wr(2'h1, `REG_CFG_RD, 8'h00);
    dev_rd(`DEV_ADDR_MAIN, m_val(m_ptr));
    dev_wr(2'h2, `REG_ONESHOT, 8'($random(seed)));
    check(shots[7:0], 8'h01);
    dev_wr(2'h2, `REG_CFG_WR, 8'h00);
    dev_wr(2'h2, `REG_ONESHOT, 8'h5A);
    check({shots[6:0], standby}, 8'h02);
    $display("test standby done");
    status_live <= 8'($random(seed));
    open_comparator <= 1'b1;
    conv_start <= 1'b1;
    @(posedge hclk);
    conv_start <= 1'b0;
    open_comparator <= 1'b0;
    m_open = 1'b1;
    alert_is(1'b1);
    dev_wr(2'h1, `REG_STATUS, 8'h00);
    dev_rd(`DEV_ADDR_MAIN, m_val(m_ptr));
    m_open = 1'b0;
    dev_rd(`DEV_ADDR_MAIN, m_val(m_ptr));
    dev_rd(`ALERT_RESP_ADDR, {`DEV_ADDR_MAIN, 1'b1});
    alert_is(1'b0);
    $display("test open_flag done");
    dev_wr(2'h2, `REG_CFG_WR, 8'h40);
    out_of_limit <= 1'b1;
    alert_is(1'b1);
    dev_rd(`ALERT_RESP_ADDR, {`DEV_ADDR_MAIN, 1'b1});
    alert_is(1'b1);
    out_of_limit <= 1'b0;
    dev_rd(`ALERT_RESP_ADDR, {`DEV_ADDR_MAIN, 1'b1});
    alert_is(1'b0);
    alert_mode <= 1'b0;
    out_of_limit <= 1'b1;
    dev_wr(2'h1, `REG_CFG_RD, 8'h00);
    dev_rd(`DEV_ADDR_MAIN, m_val(m_ptr));
    alert_is(1'b0);
    out_of_limit <= 1'b0;
    alert_mode <= 1'b1;
    $display("test alert done");
    repeat (4)
    begin
      p = 8'h40 + 8'($random(seed) & 32'h1F);
      dev_wr(2'h2, p, 8'($random(seed)));
      adr_q.push_back(p);
    end
    while (adr_q.size() > 0)
    begin
      p = adr_q.pop_front();
      dev_wr(2'h1, p, 8'h00);
      dev_rd(`DEV_ADDR_MAIN, m_val(p));
    end
    $display("test user_regs done");
    wrap_up();
  end
endmodule // smbus_slave_alert_standby_tb_top
